/* hw/mitc_instr_timing_ctrl.sv */
// mitc top: instruction sequencer with cycle timing, watchdog flags and apb registers
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module mitc_instr_timing_ctrl
    import mitc_pkg::*;
#(
    parameter int DM_AW = 6,
    parameter int ROM_AW = 8,
    parameter int STACK_DEPTH = 16,
    parameter int WDOG_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core status
    output logic sysClockStopped
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    typedef struct packed {
        mitc_state_t state;
        logic [31:0] cmd;
        logic [7:0] acc;
        logic [13:0] pc;
        logic [7:0] tableHighByte;
        logic [STACK_DEPTH-1:0][13:0] stack;
        logic [SP_W-1:0] sp;
        logic [WDOG_W-1:0] watchdogCounter;
        logic timeoutFlag;
        logic powerdownFlag;
        logic preclearFirst;
        logic preclearSecond;
        logic lastSkip;
        logic startTimer;
        logic [1:0] mcCount;
        logic [3:0] clkCnt;
        logic [3:0] lastClks;
        logic [DM_AW-1:0] dmAddr;
        logic [ROM_AW-1:0] romAddr;
        logic clockStop;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } mitc_regs_t;

    mitc_regs_t r;
    mitc_regs_t n;

    logic [7:0] dmem [2**DM_AW];
    logic [15:0] romMem [2**ROM_AW];
    logic dmWe;
    logic [DM_AW-1:0] dmWa;
    logic [7:0] dmWd;
    logic romWe;
    logic timerBusy;
    logic timerDone;
    logic execDone;
    logic apbDone;
    mitc_op_t opX;
    mitc_op_t opNew;
    logic [DM_AW-1:0] addrX;
    logic [DM_AW-1:0] addrNew;
    logic [2:0] bitX;
    logic [7:0] immX;
    logic [7:0] mX;
    logic [7:0] mNew;
    logic [7:0] wrVal;
    logic wrEn;
    logic wrPcLow;
    logic skipNow;
    logic jump;
    logic wdtClr;
    logic [13:0] tableAddr;
    logic [15:0] romWord;
    logic [SP_W-1:0] spDec;
    logic [1:0] mcNew;

    function automatic logic skipCond(mitc_op_t op, logic [7:0] m, logic [2:0] b);
        logic s;
        s = 1'b0;
        case (op)
            OP_SKIP_ZERO, OP_SKIP_ZERO_ACC: s = (m == 8'h00);
            OP_SKIP_BIT_CLR: s = ~m[b];
            OP_SKIP_BIT_SET: s = m[b];
            OP_INC_SKIP, OP_INC_SKIP_ACC: s = (m == 8'hff);
            OP_DEC_SKIP, OP_DEC_SKIP_ACC: s = (m == 8'h01);
            default: s = 1'b0;
        endcase
        return s;
    endfunction

    function automatic logic writesMem(mitc_op_t op);
        logic w;
        w = 1'b0;
        case (op)
            OP_MOV_M_A, OP_CLR_BIT, OP_SET_BIT, OP_INC_SKIP, OP_DEC_SKIP, OP_TBL_CUR, OP_TBL_LAST,
            OP_CLR_M, OP_SET_M, OP_SWAP: w = 1'b1;
            default: w = 1'b0;
        endcase
        return w;
    endfunction

    function automatic logic [1:0] baseMc(mitc_op_t op);
        logic [1:0] c;
        c = MC_ONE;
        case (op)
            OP_CALL, OP_RET, OP_RET_A_X, OP_TBL_CUR, OP_TBL_LAST: c = MC_TWO;
            default: c = MC_ONE;
        endcase
        return c;
    endfunction

    mitc_cycle_timer i_mitc_cycle_timer (
        .clk(clk),
        .rst(rst),
        .start(r.startTimer),
        .mcCount(r.mcCount),
        .busy(timerBusy),
        .done(timerDone)
    );

    // operand fetch; pc low byte is mapped into data memory
    always_comb begin
        opX = mitc_op_t'(r.cmd[CMD_OP_LSB +: 5]);
        opNew = mitc_op_t'(pwdata[CMD_OP_LSB +: 5]);
        addrX = r.cmd[CMD_ADDR_LSB +: DM_AW];
        addrNew = pwdata[CMD_ADDR_LSB +: DM_AW];
        bitX = r.cmd[CMD_BIT_LSB +: 3];
        immX = r.cmd[CMD_IMM_LSB +: 8];
        mX = (addrX == DM_AW'(PC_LOW_ADDR)) ? r.pc[7:0] : dmem[addrX];
        mNew = (addrNew == DM_AW'(PC_LOW_ADDR)) ? r.pc[7:0] : dmem[addrNew];
        wrPcLow = (addrX == DM_AW'(PC_LOW_ADDR));
        tableAddr = (opX == OP_TBL_LAST) ? {LAST_PAGE, immX} : {r.pc[13:8], immX};
        romWord = romMem[tableAddr[ROM_AW-1:0]];
        spDec = r.sp - SP_W'(1);
        // base cycles plus pc-low penalty plus skip penalty
        mcNew = baseMc(opNew)
            + {1'b0, writesMem(opNew) && (addrNew == DM_AW'(PC_LOW_ADDR))}
            + {1'b0, skipCond(opNew, mNew, pwdata[CMD_BIT_LSB +: 3])};
    end

    assign execDone = (r.state == ST_EXEC) && timerDone;
    assign apbDone = psel && penable && r.pready;

    always_comb begin
        n = r;
        n.startTimer = 1'b0;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        dmWe = 1'b0;
        dmWa = r.dmAddr;
        dmWd = 8'h00;
        romWe = 1'b0;
        wrEn = 1'b0;
        wrVal = 8'h00;
        skipNow = 1'b0;
        jump = 1'b0;
        wdtClr = 1'b0;

        // apb access phase answer, one wait cycle
        if (psel && penable && !r.pready) begin
            n.pready = 1'b1;
            n.prdata = 32'h0000_0000;
            case (paddr)
                OFF_CMD: n.prdata = r.cmd;
                OFF_STATUS: n.prdata = {25'h0, r.lastSkip, r.preclearSecond, r.preclearFirst,
                    r.powerdownFlag, r.timeoutFlag, r.state == ST_HALT, r.state != ST_IDLE};
                OFF_ACC: n.prdata = {24'h0, r.acc};
                OFF_PC: n.prdata = {18'h0, r.pc};
                OFF_TBLHI: n.prdata = {24'h0, r.tableHighByte};
                OFF_WDOG: n.prdata = 32'(r.watchdogCounter);
                OFF_DMADDR: n.prdata = 32'(r.dmAddr);
                OFF_DMDATA: n.prdata = {24'h0, dmem[r.dmAddr]};
                OFF_ROMADDR: n.prdata = 32'(r.romAddr);
                OFF_ROMDATA: n.prdata = {16'h0, romMem[r.romAddr]};
                OFF_CYCLES: n.prdata = {28'h0, r.lastClks};
                default: n.pslverr = 1'b1;
            endcase
            if (pwrite && r.state != ST_IDLE &&
                (paddr == OFF_CMD || paddr == OFF_ACC || paddr == OFF_DMDATA)) begin
                n.pslverr = 1'b1;
            end
        end

        // apb write effects at the completing edge
        if (apbDone && pwrite && !r.pslverr) begin
            case (paddr)
                OFF_CMD: begin
                    if (r.state == ST_IDLE) begin
                        n.cmd = pwdata;
                        n.state = ST_EXEC;
                        n.startTimer = 1'b1;
                        n.mcCount = mcNew;
                        n.clkCnt = 4'h0;
                    end
                end
                OFF_STATUS: begin
                    if (pwdata[ST_WAKE_BIT] && r.state == ST_HALT) begin
                        n.state = ST_IDLE;
                    end
                end
                OFF_ACC: n.acc = pwdata[7:0];
                OFF_DMADDR: n.dmAddr = pwdata[DM_AW-1:0];
                OFF_DMDATA: begin
                    dmWe = 1'b1;
                    dmWd = pwdata[7:0];
                end
                OFF_ROMADDR: n.romAddr = pwdata[ROM_AW-1:0];
                OFF_ROMDATA: romWe = 1'b1;
                default: n.state = r.state;
            endcase
        end

        // clocks spent in the running instruction
        if (timerBusy) begin
            n.clkCnt = r.clkCnt + 4'h1;
        end

        // instruction effects land when the timer runs out
        if (execDone) begin
            n.state = ST_IDLE;
            skipNow = skipCond(opX, mX, bitX);
            case (opX)
                OP_MOV_A_M: n.acc = mX;
                OP_MOV_M_A: begin
                    wrEn = 1'b1;
                    wrVal = r.acc;
                end
                OP_MOV_A_X: n.acc = immX;
                OP_CLR_BIT: begin
                    wrEn = 1'b1;
                    wrVal = mX & ~(8'h01 << bitX);
                end
                OP_SET_BIT: begin
                    wrEn = 1'b1;
                    wrVal = mX | (8'h01 << bitX);
                end
                OP_SKIP_ZERO_ACC: n.acc = mX;
                OP_INC_SKIP: begin
                    wrEn = 1'b1;
                    wrVal = mX + 8'h01;
                end
                OP_DEC_SKIP: begin
                    wrEn = 1'b1;
                    wrVal = mX - 8'h01;
                end
                OP_INC_SKIP_ACC: n.acc = mX + 8'h01;
                OP_DEC_SKIP_ACC: n.acc = mX - 8'h01;
                OP_CALL: begin
                    n.stack[r.sp] = r.pc + 14'h0001;
                    n.sp = r.sp + SP_W'(1);
                    n.pc = r.cmd[CMD_ADDR_LSB +: 14];
                    jump = 1'b1;
                end
                OP_RET: begin
                    n.sp = spDec;
                    n.pc = r.stack[spDec];
                    jump = 1'b1;
                end
                OP_RET_A_X: begin
                    n.acc = immX;
                    n.sp = spDec;
                    n.pc = r.stack[spDec];
                    jump = 1'b1;
                end
                OP_TBL_CUR, OP_TBL_LAST: begin
                    wrEn = 1'b1;
                    wrVal = romWord[7:0];
                    n.tableHighByte = romWord[15:8];
                end
                OP_CLR_M: wrEn = 1'b1;
                OP_SET_M: begin
                    wrEn = 1'b1;
                    wrVal = 8'hff;
                end
                OP_WD_CLEAR: begin
                    wdtClr = 1'b1;
                    n.timeoutFlag = 1'b0;
                    n.powerdownFlag = 1'b0;
                    n.preclearFirst = 1'b0;
                    n.preclearSecond = 1'b0;
                end
                OP_WD_PRE1, OP_WD_PRE2: begin
                    if ((opX == OP_WD_PRE1) ? r.preclearSecond : r.preclearFirst) begin
                        wdtClr = 1'b1;
                        n.timeoutFlag = 1'b0;
                        n.powerdownFlag = 1'b0;
                        n.preclearFirst = 1'b0;
                        n.preclearSecond = 1'b0;
                    end else if (opX == OP_WD_PRE1) begin
                        n.preclearFirst = 1'b1;
                    end else begin
                        n.preclearSecond = 1'b1;
                    end
                end
                OP_SWAP: begin
                    wrEn = 1'b1;
                    wrVal = {mX[3:0], mX[7:4]};
                end
                OP_SWAPA: n.acc = {mX[3:0], mX[7:4]};
                OP_HALT: begin
                    n.state = ST_HALT;
                    wdtClr = 1'b1;
                    n.powerdownFlag = 1'b1;
                    n.timeoutFlag = 1'b0;
                end
                default: n.acc = r.acc;
            endcase
            // skip consumes the next word without running it
            if (wrEn && wrPcLow) begin
                n.pc = {r.pc[13:8], wrVal};
            end else if (!jump) begin
                n.pc = r.pc + (skipNow ? 14'h0002 : 14'h0001);
            end
            if (wrEn && !wrPcLow) begin
                dmWe = 1'b1;
                dmWa = addrX;
                dmWd = wrVal;
            end
            n.lastSkip = skipNow;
            n.lastClks = r.clkCnt;
        end

        // watchdog; an overflow beats a clear in the same cycle
        n.watchdogCounter = wdtClr ? '0 : r.watchdogCounter + WDOG_W'(1);
        if (&r.watchdogCounter) begin
            n.timeoutFlag = 1'b1;
            if (r.state == ST_HALT) begin
                n.state = ST_IDLE;
            end
        end
        n.clockStop = (n.state == ST_HALT);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    always_ff @(posedge clk) begin
        if (dmWe) begin
            dmem[dmWa] <= dmWd;
        end
        if (romWe) begin
            romMem[r.romAddr] <= pwdata[15:0];
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign sysClockStopped = r.clockStop;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_BASE_CYCLE: assert property (r.startTimer && r.mcCount == MC_ONE |-> ##4 !timerDone ##1 timerDone)
        else $error("one machine cycle did not last four clocks");
    AST_RET_LIT_TWO: assert property (r.startTimer && opX == OP_RET_A_X |-> r.mcCount == MC_TWO)
        else $error("return with literal not two machine cycles");
    AST_SKIP_CLKS: assert property (execDone && skipNow && !(wrEn && wrPcLow) && baseMc(opX) == MC_ONE
        |=> r.lastClks == 4'h8)
        else $error("taken skip did not add one machine cycle");
    AST_PC_LOW_CLKS: assert property (execDone && wrEn && wrPcLow && !skipNow && baseMc(opX) == MC_ONE
        |=> r.lastClks == 4'h8)
        else $error("pc low write did not add one machine cycle");
    AST_NOSKIP_PC: assert property (execDone && !skipNow && !jump && !(wrEn && wrPcLow)
        |=> r.pc == $past(r.pc) + 14'h0001)
        else $error("pc did not step by one");
    AST_SKIP_PC: assert property (execDone && skipNow && !(wrEn && wrPcLow)
        |=> r.pc == $past(r.pc) + 14'h0002 && r.state == ST_IDLE)
        else $error("skipped word not passed over");
    AST_HALT: assert property (execDone && opX == OP_HALT && !(&r.watchdogCounter)
        |=> r.state == ST_HALT && r.powerdownFlag && !r.timeoutFlag && sysClockStopped)
        else $error("power-down effects missing");
    AST_WD_CLEAR: assert property (execDone && opX == OP_WD_CLEAR && !(&r.watchdogCounter)
        |=> !r.timeoutFlag && !r.powerdownFlag && r.watchdogCounter == '0)
        else $error("watchdog clear effects missing");
    AST_PRE_HOLD: assert property (execDone && opX == OP_WD_PRE1 && !r.preclearSecond
        && !(&r.watchdogCounter) |=> $stable(r.timeoutFlag) && $stable(r.powerdownFlag) && r.preclearFirst)
        else $error("lone preclear changed flags");
    AST_PRE_PAIR: assert property (execDone && opX == OP_WD_PRE2 && r.preclearFirst
        && !(&r.watchdogCounter) |=> !r.timeoutFlag && !r.powerdownFlag && r.watchdogCounter == '0)
        else $error("preclear pair did not clear");
    AST_CALL: assert property (execDone && opX == OP_CALL
        |=> r.pc == $past(r.cmd[CMD_ADDR_LSB +: 14]) && r.stack[$past(r.sp)] == $past(r.pc) + 14'h0001)
        else $error("call push or target wrong");

    COV_SKIP: cover property (execDone && skipNow);
    COV_PC_LOW: cover property (execDone && wrEn && wrPcLow);
    COV_HALT: cover property (execDone && opX == OP_HALT);
    COV_PAIR: cover property (execDone && opX == OP_WD_PRE2 && r.preclearFirst);
endmodule
`default_nettype wire

/* hw/mitc_pkg.sv */
// mitc package: register map, command fields, opcodes, states and timing constants
// Behaviour
// - move memory-to-acc, acc-to-memory, immediate-to-acc in one machine cycle, no flags
// - clear or set one chosen bit of a memory byte in one machine cycle
// - bit selector field picks bit 0 through 7 of the addressed byte
// - zero test on a memory byte skips next instruction when zero; one cycle otherwise
// - zero test variant also copies the tested byte into the accumulator
// - bit tests skip when selected bit is zero, or when it is one
// - increment/decrement test writes back to memory, skips on zero; both penalties possible
// - accumulator forms of increment/decrement test only pay the skip penalty
// - return with literal loads accumulator and returns in two machine cycles
// - current-page table read: low byte to memory, high byte to table high, two cycles
// - last-page table read does the same from the final program page
// - nibble swap in place or into accumulator, one cycle, no flags
// - power-down takes one machine cycle and updates timeout and power-down flags
// - writing the pc low byte adds one machine cycle of four clocks
// - a taken skip adds one machine cycle; otherwise base count stays
// - preclear pair clears timeout and power-down flags only when watchdog is cleared
// - call pushes address of next instruction, then loads the target
// - power-down stops execution, clears watchdog, sets power-down flag, clears timeout
// - watchdog clear zeroes counter and clears power-down and timeout flags
// - one preclear alone only records itself; counter and flags unchanged
`default_nettype none
package mitc_pkg;
    localparam int MC_CLKS = 4;
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_ACC = 8'h08;
    localparam logic [7:0] OFF_PC = 8'h0c;
    localparam logic [7:0] OFF_TBLHI = 8'h10;
    localparam logic [7:0] OFF_WDOG = 8'h14;
    localparam logic [7:0] OFF_DMADDR = 8'h18;
    localparam logic [7:0] OFF_DMDATA = 8'h1c;
    localparam logic [7:0] OFF_ROMADDR = 8'h20;
    localparam logic [7:0] OFF_ROMDATA = 8'h24;
    localparam logic [7:0] OFF_CYCLES = 8'h28;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BIT_LSB = 5;
    localparam int CMD_IMM_LSB = 8;
    localparam int CMD_ADDR_LSB = 16;
    localparam int ST_WAKE_BIT = 0;
    localparam logic [7:0] PC_LOW_ADDR = 8'h02;
    localparam logic [5:0] LAST_PAGE = 6'h3f;
    localparam logic [1:0] MC_ONE = 2'h1;
    localparam logic [1:0] MC_TWO = 2'h2;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_MOV_A_M = 5'h01,
        OP_MOV_M_A = 5'h02,
        OP_MOV_A_X = 5'h03,
        OP_CLR_BIT = 5'h04,
        OP_SET_BIT = 5'h05,
        OP_SKIP_ZERO = 5'h06,
        OP_SKIP_ZERO_ACC = 5'h07,
        OP_SKIP_BIT_CLR = 5'h08,
        OP_SKIP_BIT_SET = 5'h09,
        OP_INC_SKIP = 5'h0a,
        OP_DEC_SKIP = 5'h0b,
        OP_INC_SKIP_ACC = 5'h0c,
        OP_DEC_SKIP_ACC = 5'h0d,
        OP_CALL = 5'h0e,
        OP_RET = 5'h0f,
        OP_RET_A_X = 5'h10,
        OP_TBL_CUR = 5'h11,
        OP_TBL_LAST = 5'h12,
        OP_CLR_M = 5'h13,
        OP_SET_M = 5'h14,
        OP_WD_CLEAR = 5'h15,
        OP_WD_PRE1 = 5'h16,
        OP_WD_PRE2 = 5'h17,
        OP_SWAP = 5'h18,
        OP_SWAPA = 5'h19,
        OP_HALT = 5'h1a
    } mitc_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_HALT = 2'b10
    } mitc_state_t;
endpackage
`default_nettype wire

/* hw/mitc_cycle_timer.sv */
// mitc machine-cycle timer: counts four system clocks per machine cycle
`timescale 1ns/1ps
`default_nettype none
module mitc_cycle_timer
    import mitc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request
    input wire logic start,
    input wire logic [1:0] mcCount,
    // progress
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [3:0] left;
        logic busy;
        logic done;
    } mitc_tmr_t;

    mitc_tmr_t r;
    mitc_tmr_t n;

    always_comb begin
        n = r;
        n.done = 1'b0;
        if (start) begin
            n.left = 4'(4'(mcCount) * 4'(MC_CLKS) - 4'h1);
            n.busy = 1'b1;
        end else if (r.busy) begin
            if (r.left == 4'h0) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end else begin
                n.left = r.left - 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign busy = r.busy;
    assign done = r.done;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// mitc testbench: apb driver, expectation queue and output monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mitc_pkg::*;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} mitc_exp_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdv;
    logic pready;
    logic pslverr;
    logic sysClockStopped;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    mitc_exp_t q[$];
    mitc_exp_t cur;
    logic [13:0] pcM;
    logic [13:0] t1;
    logic [13:0] t2;
    logic [7:0] accM;
    logic [7:0] v;
    logic [7:0] r;
    logic [7:0] w;
    logic [15:0] x16;
    logic [2:0] b;
    logic sk;
    always #2 clk = ~clk;
    mitc_instr_timing_ctrl #(.WDOG_W(13), .ROM_AW(14)) i_mitc_instr_timing_ctrl (.clk(clk), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sysClockStopped(sysClockStopped));
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // monitor: oldest note against each completed transfer
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            cur = q.pop_front();
            chk("pslverr", {31'h0, pslverr}, {31'h0, cur.e});
            if (!pwrite) chk("prdata", prdata & cur.m, cur.d & cur.m);
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic apb(logic [7:0] a, logic wr, logic [31:0] wd, logic [31:0] ed, logic [31:0] m, logic e);
        q.push_back('{ed, m, e});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d, logic e = 1'b0);
        apb(a, 1'b1, d, 32'h0, 32'h0, e);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] d, logic [31:0] m = 32'hffffffff);
        apb(a, 1'b0, 32'h0, d, m, 1'b0);
    endtask
    task automatic wt;
        do rd(OFF_STATUS, 32'h0, 32'h0); while (rdv[0] !== 1'b0 && rdv[1] !== 1'b1);
    endtask
    task automatic ex(logic [4:0] op, logic [7:0] imm, logic [13:0] ad, logic [2:0] bs = 3'h0);
        wr(OFF_CMD, {2'h0, ad, imm, bs, op});
        wt();
    endtask
    task automatic fin(logic [31:0] c);
        rd(OFF_CYCLES, c);
        rd(OFF_PC, {18'h0, pcM});
        rd(OFF_ACC, {24'h0, accM});
        rd(OFF_STATUS, 32'h0, 32'h0c);
    endtask
    task automatic sm(logic [5:0] a, logic [7:0] d);
        wr(OFF_DMADDR, {26'h0, a});
        wr(OFF_DMDATA, {24'h0, d});
    endtask
    task automatic cm(logic [5:0] a, logic [7:0] d);
        wr(OFF_DMADDR, {26'h0, a});
        rd(OFF_DMDATA, {24'h0, d});
    endtask
    initial begin
        rdv = $urandom(32'h9227);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        pcM = 14'h0;
        accM = 8'h0;
        rd(OFF_STATUS, 32'h0);
        rd(OFF_TBLHI, 32'h0);
        apb(8'h2c, 1'b0, 32'h0, 32'h0, 32'hffffffff, 1'b1);
        wr(8'h30, 32'h1, 1'b1);
        w = 8'($urandom);
        ex(OP_MOV_A_X, w, 14'h0);
        accM = w;
        pcM++;
        fin(4);
        ex(OP_MOV_M_A, 8'h0, 14'h5);
        pcM++;
        cm(6'h5, w);
        wr(OFF_CMD, {27'h0, OP_MOV_A_X});
        wr(OFF_CMD, 32'h0, 1'b1);
        wt();
        accM = 8'h0;
        ex(OP_MOV_A_M, 8'h0, 14'h5);
        accM = w;
        pcM = pcM + 14'h2;
        fin(4);
        for (int i = 0; i < 8; i++) begin
            sm(6'h7, 8'hff);
            ex(OP_CLR_BIT, 8'h0, 14'h7, i[2:0]);
            cm(6'h7, ~(8'h1 << i));
            ex(OP_SET_BIT, 8'h0, 14'h7, i[2:0]);
            pcM = pcM + 14'h2;
            fin(4);
            cm(6'h7, 8'hff);
        end
        for (int o = 6; o < 14; o++) begin
            for (int k = 0; k < 4; k++) begin
                v = (k == 0) ? 8'h0 : (k == 1) ? 8'hff : (k == 2) ? 8'h1 : 8'($urandom);
                b = 3'($urandom);
                sm(6'h9, v);
                ex(5'(o), 8'h0, 14'h9, b);
                r = (o == 10 || o == 12) ? v + 8'h1 : (o == 11 || o == 13) ? v - 8'h1 : v;
                sk = (o == 8) ? !v[b] : (o == 9) ? v[b] : (r == 8'h0);
                if (o == 7 || o > 11) accM = r;
                pcM = pcM + (sk ? 14'h2 : 14'h1);
                fin(sk ? 32'h8 : 32'h4);
                cm(6'h9, (o == 10 || o == 11) ? r : v);
                rd(OFF_STATUS, {25'h0, sk, 6'h0}, 32'h40);
            end
        end
        ex(OP_MOV_A_X, 8'hff, 14'h0);
        accM = 8'hff;
        pcM[7:0] = 8'hff;
        ex(OP_MOV_M_A, 8'h0, 14'h2);
        fin(8);
        ex(OP_INC_SKIP, 8'h0, 14'h2);
        pcM = 14'h0;
        fin(32'hc);
        t1 = 14'($urandom);
        t2 = 14'($urandom);
        ex(OP_CALL, 8'h0, t1);
        pcM = t1;
        fin(8);
        ex(OP_CALL, 8'h0, t2);
        pcM = t2;
        fin(8);
        w = 8'($urandom);
        ex(OP_RET_A_X, w, 14'h0);
        pcM = t1 + 14'h1;
        accM = w;
        fin(8);
        for (int p = 0; p < 2; p++) begin
            w = 8'($urandom);
            x16 = 16'($urandom);
            wr(OFF_ROMADDR, {18'h0, p ? 6'h3f : pcM[13:8], w});
            wr(OFF_ROMDATA, {16'h0, x16});
            ex(p ? OP_TBL_LAST : OP_TBL_CUR, w, 14'hb);
            pcM++;
            fin(8);
            cm(6'hb, x16[7:0]);
            rd(OFF_TBLHI, {24'h0, x16[15:8]});
        end
        ex(OP_RET, 8'h0, 14'h0);
        pcM = 14'h1;
        fin(8);
        v = 8'($urandom);
        sm(6'hc, v);
        ex(OP_SWAPA, 8'h0, 14'hc);
        accM = {v[3:0], v[7:4]};
        pcM++;
        fin(4);
        cm(6'hc, v);
        ex(OP_SWAP, 8'h0, 14'hc);
        pcM++;
        fin(4);
        cm(6'hc, {v[3:0], v[7:4]});
        ex(OP_HALT, 8'h0, 14'h0);
        rd(OFF_STATUS, 32'ha, 32'h0e);
        rd(OFF_CYCLES, 32'h4);
        rd(OFF_WDOG, 32'h0, 32'hff00);
        chk("sysClockStopped", {31'h0, sysClockStopped}, 32'h1);
        wr(OFF_CMD, 32'h0, 1'b1);
        do @(posedge clk); while (sysClockStopped !== 1'b0);
        rd(OFF_STATUS, 32'h0c, 32'h0e);
        ex(OP_WD_PRE1, 8'h0, 14'h0);
        ex(OP_WD_PRE1, 8'h0, 14'h0);
        rd(OFF_STATUS, 32'h1c, 32'h3e);
        ex(OP_WD_PRE2, 8'h0, 14'h0);
        rd(OFF_STATUS, 32'h0, 32'h3e);
        rd(OFF_WDOG, 32'h0, 32'hff00);
        ex(OP_HALT, 8'h0, 14'h0);
        wr(OFF_STATUS, 32'h1);
        ex(OP_WD_CLEAR, 8'h0, 14'h0);
        rd(OFF_STATUS, 32'h0, 32'h0e);
        rd(OFF_WDOG, 32'h0, 32'hff00);
        test_done();
    end
endmodule
`default_nettype wire
